// *** dsa_alarm.sv ***
// Purpose: Two setpoint alarms on the display value with keypad menu.
// Assumes: Display value and strobe come from logic on CLOCK; keys are pins.
// Notes:   Digits are 4-bit nibbles, most significant first.
`timescale 1ns/100ps
// Notes on behaviour
// - Two channels, each high or low trip.
// - Contact sense picks open or closed in alarm.
// - Display alternates value and alarm identifier.
// - Enable gates action, other settings kept.
// - Trip when value reaches or passes level.
// - Output waits programmed delay before alarming.
// - Acknowledge silences output for mute period.
// - Levels compared in display units directly.
// - Each level settable across display range.
// - Numbers edited digit by digit.
// - Options revealed, toggled, confirmed by quit.
// - Trip clears only beyond deadband or when the channel is disabled.
// - Delay 0 to 3600 s, 1 s steps.
// - Nonzero mute makes select an accept key.
// - Shortcut exits on bad code or 10 s idle.
module dsa_alarm #(
  parameter int TICK_CYCLES = dsa_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                          CLOCK,
  input  wire logic                          RST_N,
  // Measurement path
  input  wire logic signed [dsa_pkg::VAL_W-1:0] DISP_VALUE,
  input  wire logic                          DISP_STROBE,
  // Keypad pins
  input  wire dsa_pkg::dsa_keys_t            KEYS,
  // Alarm switches, high means closed
  output logic [1:0]                         SWITCH_CLOSED,
  // Display control
  output logic [1:0]                         ALARM_SHOWN,
  output logic                               SHOW_ALARM_ID,
  output dsa_pkg::dsa_state_t                MENU_STATE,
  output logic [dsa_pkg::PAR_W-1:0]          MENU_PARAM,
  output logic [dsa_pkg::VAL_W-1:0]          EDIT_VALUE,
  output logic [dsa_pkg::DIG_W-1:0]          EDIT_DIGIT
);
  localparam int TCK_W = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  function automatic logic trip_next(input logic signed [dsa_pkg::VAL_W-1:0] v,
                                     input logic signed [dsa_pkg::VAL_W-1:0] sp,
                                     input logic [dsa_pkg::VAL_W-1:0] db,
                                     input logic hi, input logic cur);
    logic signed [dsa_pkg::VAL_W+1:0] ve;
    logic signed [dsa_pkg::VAL_W+1:0] se;
    logic signed [dsa_pkg::VAL_W+1:0] de;
    begin
      ve = (dsa_pkg::VAL_W+2)'(v);
      se = (dsa_pkg::VAL_W+2)'(sp);
      de = $signed({2'b00, db});
      if (hi) trip_next = cur ? (ve >= se - de) : (ve >= se);
      else    trip_next = cur ? (ve <= se + de) : (ve <= se);
    end
  endfunction

  function automatic logic [dsa_pkg::TIME_W-1:0] clamp_time(input logic [dsa_pkg::VAL_W-1:0] v);
    clamp_time = (v > {4'h0, dsa_pkg::TIME_MAX_S}) ? dsa_pkg::TIME_MAX_S : v[dsa_pkg::TIME_W-1:0];
  endfunction

  // Key synchronisers and press edges
  logic [3:0] key_s1_reg, key_s2_reg, key_s3_reg;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      key_s1_reg <= 4'h0;
      key_s2_reg <= 4'h0;
      key_s3_reg <= 4'h0;
    end else begin
      key_s1_reg <= KEYS;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
    end
  end
  dsa_pkg::dsa_keys_t held, press;
  assign held  = key_s2_reg;
  assign press = key_s2_reg & ~key_s3_reg;
  wire any_press = |(key_s2_reg & ~key_s3_reg);

  // One-second tick
  logic [TCK_W-1:0] tck_reg;
  wire tick = (tck_reg == TCK_W'(TICK_CYCLES - 1));
  always_ff @(posedge CLOCK) begin
    if (!RST_N) tck_reg <= '0;
    else        tck_reg <= tick ? '0 : tck_reg + 1'b1;
  end

  // Stored parameters
  dsa_pkg::dsa_chan_cfg_t       cfg_reg [2];
  logic                         short_en_reg;
  logic [dsa_pkg::VAL_W-1:0]    code_reg;

  // Menu registers
  dsa_pkg::dsa_state_t          st_reg, st_next;
  logic [dsa_pkg::PAR_W-1:0]    par_reg, par_next;
  logic [dsa_pkg::VAL_W-1:0]    edit_reg, edit_next;
  logic [dsa_pkg::DIG_W-1:0]    dig_reg, dig_next;
  logic                         via_short_reg, via_short_next;
  logic [3:0]                   idle_reg;
  logic                         commit;
  logic                         accept;

  // Parameter read decode
  wire                          par_ch  = (par_reg >= dsa_pkg::CH_FIELDS);
  wire [dsa_pkg::PAR_W-1:0]     par_fld = par_ch ? par_reg - dsa_pkg::CH_FIELDS : par_reg;
  dsa_pkg::dsa_chan_cfg_t       cfg_sel;
  assign cfg_sel = cfg_reg[par_ch];
  wire is_short_par = (par_reg == dsa_pkg::PAR_SHORT_EN) || (par_reg == dsa_pkg::PAR_CODE);
  wire is_option = (par_reg == dsa_pkg::PAR_SHORT_EN) ||
                   (!is_short_par && (par_fld == dsa_pkg::FLD_EN || par_fld == dsa_pkg::FLD_DIR ||
                                      par_fld == dsa_pkg::FLD_SENSE));
  wire [dsa_pkg::VAL_W-1:0] cur_val =
    (par_reg == dsa_pkg::PAR_CODE)     ? code_reg :
    (par_reg == dsa_pkg::PAR_SHORT_EN) ? {15'h0000, short_en_reg} :
    (par_fld == dsa_pkg::FLD_LEVEL)    ? cfg_sel.level :
    (par_fld == dsa_pkg::FLD_BAND)     ? cfg_sel.deadband :
    (par_fld == dsa_pkg::FLD_WAIT)     ? {4'h0, cfg_sel.activation_wait} :
    (par_fld == dsa_pkg::FLD_MUTE)     ? {4'h0, cfg_sel.mute_period} :
    (par_fld == dsa_pkg::FLD_EN)       ? {15'h0000, cfg_sel.en} :
    (par_fld == dsa_pkg::FLD_DIR)      ? {15'h0000, cfg_sel.dir_high} :
                                         {15'h0000, cfg_sel.close_in_alarm};
  localparam int NIB_SHIFT_W = dsa_pkg::DIG_W + 2;
  wire [NIB_SHIFT_W-1:0] nib_sh = {dig_reg, 2'b00};
  wire [dsa_pkg::NIB_W-1:0] nib = edit_reg[nib_sh +: dsa_pkg::NIB_W];
  wire timeout = (idle_reg >= 4'(dsa_pkg::IDLE_LIMIT_S));
  wire [1:0] active;
  wire any_mute = (cfg_reg[0].mute_period != '0) || (cfg_reg[1].mute_period != '0);

  // Menu sequencing
  always_comb begin
    st_next        = st_reg;
    par_next       = par_reg;
    edit_next      = edit_reg;
    dig_next       = dig_reg;
    via_short_next = via_short_reg;
    commit         = 1'b0;
    accept         = 1'b0;
    unique case (st_reg)
      dsa_pkg::DSA_ST_DISPLAY: begin
        if ((press.sel && held.up) || (press.up && held.sel)) begin
          if (short_en_reg) begin
            via_short_next = 1'b1;
            par_next       = dsa_pkg::PAR_LEVEL1;
            edit_next      = '0;
            dig_next       = dsa_pkg::DIGIT_TOP;
            st_next        = (code_reg == '0) ? dsa_pkg::DSA_ST_SHORT : dsa_pkg::DSA_ST_CODE;
          end
        end else if (press.sel) begin
          accept = any_mute && (|active);
        end else if (press.quit) begin
          via_short_next = 1'b0;
          par_next       = '0;
          st_next        = dsa_pkg::DSA_ST_PROMPT;
        end
      end
      dsa_pkg::DSA_ST_PROMPT: begin
        if (press.up) par_next = par_reg + 1'b1;
        else if (press.down) par_next = par_reg - 1'b1;
        else if (press.sel) begin
          edit_next = cur_val;
          dig_next  = dsa_pkg::DIGIT_TOP;
          st_next   = is_option ? dsa_pkg::DSA_ST_OPTION : dsa_pkg::DSA_ST_DIGIT;
        end else if (press.quit) st_next = dsa_pkg::DSA_ST_DISPLAY;
      end
      dsa_pkg::DSA_ST_DIGIT, dsa_pkg::DSA_ST_CODE: begin
        if (press.up) edit_next[nib_sh +: dsa_pkg::NIB_W] = nib + 1'b1;
        else if (press.down) edit_next[nib_sh +: dsa_pkg::NIB_W] = nib - 1'b1;
        else if (press.sel) dig_next = dig_reg - 1'b1;
        else if (press.quit) begin
          if (st_reg == dsa_pkg::DSA_ST_CODE) begin
            st_next = (edit_reg == code_reg) ? dsa_pkg::DSA_ST_SHORT : dsa_pkg::DSA_ST_DISPLAY;
          end else begin
            commit  = 1'b1;
            st_next = via_short_reg ? dsa_pkg::DSA_ST_SHORT : dsa_pkg::DSA_ST_PROMPT;
          end
        end
      end
      dsa_pkg::DSA_ST_OPTION: begin
        if (press.up || press.down) edit_next = {15'h0000, ~edit_reg[0]};
        else if (press.quit) begin
          commit  = 1'b1;
          st_next = dsa_pkg::DSA_ST_PROMPT;
        end
      end
      dsa_pkg::DSA_ST_SHORT: begin
        if (press.up || press.down)
          par_next = (par_reg == dsa_pkg::PAR_LEVEL1) ? dsa_pkg::PAR_LEVEL2 : dsa_pkg::PAR_LEVEL1;
        else if (press.sel) begin
          edit_next = cur_val;
          dig_next  = dsa_pkg::DIGIT_TOP;
          st_next   = dsa_pkg::DSA_ST_DIGIT;
        end else if (press.quit) st_next = dsa_pkg::DSA_ST_DISPLAY;
      end
      default: st_next = dsa_pkg::DSA_ST_DISPLAY;
    endcase
    if (via_short_reg && st_reg != dsa_pkg::DSA_ST_DISPLAY && timeout)
      st_next = dsa_pkg::DSA_ST_DISPLAY;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_reg        <= dsa_pkg::DSA_ST_DISPLAY;
      par_reg       <= '0;
      edit_reg      <= '0;
      dig_reg       <= dsa_pkg::DIGIT_TOP;
      via_short_reg <= 1'b0;
      idle_reg      <= 4'h0;
    end else begin
      st_reg        <= st_next;
      par_reg       <= par_next;
      edit_reg      <= edit_next;
      dig_reg       <= dig_next;
      via_short_reg <= via_short_next;
      idle_reg      <= (any_press || st_reg == dsa_pkg::DSA_ST_DISPLAY) ? 4'h0 :
                       (tick && !timeout) ? idle_reg + 4'h1 : idle_reg;
    end
  end

  // Parameter store; only the field edited changes
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int c = 0; c < 2; c++) begin
        cfg_reg[c] <= '{en: dsa_pkg::RST_EN, dir_high: dsa_pkg::RST_DIR_HIGH,
                        close_in_alarm: dsa_pkg::RST_CLOSE, default: '0};
      end
      short_en_reg <= 1'b0;
      code_reg     <= dsa_pkg::RST_CODE;
    end else if (commit) begin
      if (par_reg == dsa_pkg::PAR_CODE) code_reg <= edit_reg;
      else if (par_reg == dsa_pkg::PAR_SHORT_EN) short_en_reg <= edit_reg[0];
      else begin
        unique case (par_fld)
          dsa_pkg::FLD_EN:    cfg_reg[par_ch].en <= edit_reg[0];
          dsa_pkg::FLD_LEVEL: cfg_reg[par_ch].level <= edit_reg;
          dsa_pkg::FLD_DIR:   cfg_reg[par_ch].dir_high <= edit_reg[0];
          dsa_pkg::FLD_SENSE: cfg_reg[par_ch].close_in_alarm <= edit_reg[0];
          dsa_pkg::FLD_BAND:  cfg_reg[par_ch].deadband <= edit_reg;
          dsa_pkg::FLD_WAIT:  cfg_reg[par_ch].activation_wait <= clamp_time(edit_reg);
          dsa_pkg::FLD_MUTE:  cfg_reg[par_ch].mute_period <= clamp_time(edit_reg);
          default:            code_reg <= code_reg;
        endcase
      end
    end
  end

  // Alarm channels
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic                         cond_reg;
    logic                         act_reg;
    logic [dsa_pkg::TIME_W-1:0]   wait_reg;
    logic [dsa_pkg::TIME_W-1:0]   mute_reg;
    dsa_pkg::dsa_chan_cfg_t       cfg;
    assign cfg = cfg_reg[c];
    wire cond_next = !cfg.en ? 1'b0 :
                     DISP_STROBE ? trip_next(DISP_VALUE, $signed(cfg.level), cfg.deadband,
                                             cfg.dir_high, cond_reg) : cond_reg;
    wire [dsa_pkg::TIME_W-1:0] wait_next =
      !cond_reg ? '0 : (tick && wait_reg < cfg.activation_wait) ? wait_reg + 1'b1 : wait_reg;
    wire act_next = cfg.en && cond_reg && (wait_reg >= cfg.activation_wait);
    wire [dsa_pkg::TIME_W-1:0] mute_next =
      !act_reg ? '0 : (accept && cfg.mute_period != '0) ? cfg.mute_period :
      (tick && mute_reg != '0) ? mute_reg - 1'b1 : mute_reg;
    wire drive = act_reg && (mute_reg == '0);
    assign active[c] = act_reg;
    always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
        cond_reg         <= 1'b0;
        act_reg          <= 1'b0;
        wait_reg         <= '0;
        mute_reg         <= '0;
        SWITCH_CLOSED[c] <= ~dsa_pkg::RST_CLOSE;
        ALARM_SHOWN[c]   <= 1'b0;
      end else begin
        cond_reg         <= cond_next;
        act_reg          <= act_next;
        wait_reg         <= wait_next;
        mute_reg         <= mute_next;
        SWITCH_CLOSED[c] <= cfg.close_in_alarm ? drive : ~drive;
        ALARM_SHOWN[c]   <= act_reg;
      end
    end
  end

  // Display alternation and menu outputs
  always_ff @(posedge CLOCK) begin
    if (!RST_N) SHOW_ALARM_ID <= 1'b0;
    else        SHOW_ALARM_ID <= !(|active) ? 1'b0 : tick ? ~SHOW_ALARM_ID : SHOW_ALARM_ID;
  end
  assign MENU_STATE = st_reg;
  assign MENU_PARAM = par_reg;
  assign EDIT_VALUE = edit_reg;
  assign EDIT_DIGIT = dig_reg;
endmodule

// *** dsa_pkg.sv ***
// Purpose: Shared constants and types for the dual setpoint alarm.
// Assumes: 100 MHz system clock, 16-bit signed display value.
// Notes:   Parameter index map: 0..6 channel 1, 7..13 channel 2, 14..15 shortcut.
package dsa_pkg;
  localparam int VAL_W         = 16;
  localparam int TIME_W        = 12;
  localparam int PAR_W         = 4;
  localparam int DIG_W         = 2;
  localparam int NIB_W         = 4;
  localparam int CLK_HZ        = 100_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
  localparam int IDLE_LIMIT_S  = 10;
  localparam logic [TIME_W-1:0] TIME_MAX_S = 12'hE10;
  // Parameter indices and field codes
  localparam logic [PAR_W-1:0] FLD_EN       = 4'h0;
  localparam logic [PAR_W-1:0] FLD_LEVEL    = 4'h1;
  localparam logic [PAR_W-1:0] FLD_DIR      = 4'h2;
  localparam logic [PAR_W-1:0] FLD_SENSE    = 4'h3;
  localparam logic [PAR_W-1:0] FLD_BAND     = 4'h4;
  localparam logic [PAR_W-1:0] FLD_WAIT     = 4'h5;
  localparam logic [PAR_W-1:0] FLD_MUTE     = 4'h6;
  localparam logic [PAR_W-1:0] CH_FIELDS    = 4'h7;
  localparam logic [PAR_W-1:0] PAR_SHORT_EN = 4'hE;
  localparam logic [PAR_W-1:0] PAR_CODE     = 4'hF;
  localparam logic [PAR_W-1:0] PAR_LEVEL1   = 4'h1;
  localparam logic [PAR_W-1:0] PAR_LEVEL2   = 4'h8;
  localparam logic [DIG_W-1:0] DIGIT_TOP    = 2'h3;
  // Reset values
  localparam logic             RST_EN       = 1'b0;
  localparam logic             RST_DIR_HIGH = 1'b1;
  localparam logic             RST_CLOSE    = 1'b0;
  localparam logic [VAL_W-1:0] RST_CODE     = 16'h0000;

  typedef enum logic [2:0] {
    DSA_ST_DISPLAY = 3'h0,
    DSA_ST_PROMPT  = 3'h1,
    DSA_ST_DIGIT   = 3'h2,
    DSA_ST_OPTION  = 3'h3,
    DSA_ST_CODE    = 3'h4,
    DSA_ST_SHORT   = 3'h5
  } dsa_state_t;

  typedef struct packed {
    logic              en;
    logic              dir_high;
    logic              close_in_alarm;
    logic [VAL_W-1:0]  level;
    logic [VAL_W-1:0]  deadband;
    logic [TIME_W-1:0] activation_wait;
    logic [TIME_W-1:0] mute_period;
  } dsa_chan_cfg_t;

  typedef struct packed {
    logic up;
    logic down;
    logic sel;
    logic quit;
  } dsa_keys_t;
endpackage

// *** dsa_alarm_props.sv ***
// Purpose: Port checks for the dual setpoint alarm.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound onto every dsa_alarm instance.
`timescale 1ns/100ps
module dsa_alarm_props #(
  parameter int TICK_CYCLES = dsa_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic                             CLOCK,
  input wire logic                             RST_N,
  // Inputs
  input wire logic signed [dsa_pkg::VAL_W-1:0] DISP_VALUE,
  input wire logic                             DISP_STROBE,
  input wire dsa_pkg::dsa_keys_t               KEYS,
  // Outputs
  input wire logic [1:0]                       SWITCH_CLOSED,
  input wire logic [1:0]                       ALARM_SHOWN,
  input wire logic                             SHOW_ALARM_ID,
  input wire dsa_pkg::dsa_state_t              MENU_STATE,
  input wire logic [dsa_pkg::PAR_W-1:0]        MENU_PARAM,
  input wire logic [dsa_pkg::VAL_W-1:0]        EDIT_VALUE,
  input wire logic [dsa_pkg::DIG_W-1:0]        EDIT_DIGIT
);
  localparam int IDLE_MAX = dsa_pkg::IDLE_LIMIT_S * TICK_CYCLES + 4;
  int id_cnt;
  int idle_cnt;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Cycles since the identifier last flipped while an alarm shows
  always_ff @(posedge CLOCK) begin
    if (!RST_N || ALARM_SHOWN == 2'h0 || $changed(SHOW_ALARM_ID))
      id_cnt <= 0;
    else
      id_cnt <= id_cnt + 1;
  end
  // Cycles spent idle at the shortcut prompt
  always_ff @(posedge CLOCK) begin
    if (!RST_N || MENU_STATE != dsa_pkg::DSA_ST_SHORT || KEYS != 4'h0)
      idle_cnt <= 0;
    else
      idle_cnt <= idle_cnt + 1;
  end
  sequence quiet_s;
    (ALARM_SHOWN == 2'h0 && MENU_STATE == dsa_pkg::DSA_ST_DISPLAY) [*4];
  endsequence
  sequence stay_s(st);
    MENU_STATE == st && $past(MENU_STATE) == st;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0) !RST_N |=> SWITCH_CLOSED == 2'h3
    && ALARM_SHOWN == 2'h0 && MENU_STATE == dsa_pkg::DSA_ST_DISPLAY) else $error("outputs not at reset values");
  sw_quiet_a: assert property (quiet_s |-> $stable(SWITCH_CLOSED))
    else $error("switch moved with no alarm");
  id_rise_a: assert property ($rose(SHOW_ALARM_ID) |-> ##[0:1] ALARM_SHOWN != 2'h0)
    else $error("identifier shown without alarm");
  id_period_a: assert property (id_cnt <= TICK_CYCLES + 2)
    else $error("identifier stopped alternating");
  digit_step_a: assert property (stay_s(dsa_pkg::DSA_ST_DIGIT) ##0 $changed(EDIT_DIGIT)
    |-> EDIT_DIGIT == $past(EDIT_DIGIT) - 2'h1) else $error("digit did not step down");
  nibble_only_a: assert property (stay_s(dsa_pkg::DSA_ST_DIGIT) |->
    ((EDIT_VALUE ^ $past(EDIT_VALUE)) & ~(16'hF << (4 * $past(EDIT_DIGIT)))) == 16'h0)
    else $error("edit touched another digit");
  digit_start_a: assert property (MENU_STATE == dsa_pkg::DSA_ST_DIGIT && $past(MENU_STATE) != MENU_STATE
    |-> EDIT_DIGIT == dsa_pkg::DIGIT_TOP) else $error("edit not started at top digit");
  option_bit_a: assert property (stay_s(dsa_pkg::DSA_ST_OPTION) |-> EDIT_VALUE[15:1] == $past(EDIT_VALUE[15:1]))
    else $error("option edit touched upper bits");
  param_step_a: assert property (stay_s(dsa_pkg::DSA_ST_PROMPT) ##0 $changed(MENU_PARAM)
    |-> MENU_PARAM == $past(MENU_PARAM) + 4'h1 || MENU_PARAM == $past(MENU_PARAM) - 4'h1)
    else $error("prompt skipped a parameter");
  idle_exit_a: assert property (idle_cnt <= IDLE_MAX)
    else $error("shortcut idle exit late");
endmodule
bind dsa_alarm dsa_alarm_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.CLOCK(CLOCK), .RST_N(RST_N),
  .DISP_VALUE(DISP_VALUE), .DISP_STROBE(DISP_STROBE), .KEYS(KEYS), .SWITCH_CLOSED(SWITCH_CLOSED),
  .ALARM_SHOWN(ALARM_SHOWN), .SHOW_ALARM_ID(SHOW_ALARM_ID), .MENU_STATE(MENU_STATE),
  .MENU_PARAM(MENU_PARAM), .EDIT_VALUE(EDIT_VALUE), .EDIT_DIGIT(EDIT_DIGIT));

// *** dsa_keypad.sv ***
// Purpose: Operator keypad model for the dual setpoint alarm.
// Assumes: Keys are active high levels.
// Notes:   Hold and release spans clear the two-stage key sync.
`timescale 1ns/100ps
module dsa_keypad (
  // Clock
  input wire logic           clock,
  // Key pins
  output dsa_pkg::dsa_keys_t keys
);
  initial keys = 4'h0;
  task automatic press(input dsa_pkg::dsa_keys_t k);
    @(posedge clock) keys <= k;
    repeat (3) @(posedge clock);
    keys <= 4'h0;
    repeat (4) @(posedge clock);
  endtask
  // Second key rises while the first is still held
  task automatic chord(input dsa_pkg::dsa_keys_t first, input dsa_pkg::dsa_keys_t both);
    @(posedge clock) keys <= first;
    repeat (3) @(posedge clock);
    keys <= both;
    repeat (3) @(posedge clock);
    keys <= 4'h0;
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** dsa_alarm_bench.sv ***
// Purpose: Self-checking bench for the dual setpoint alarm.
// Assumes: Tick shortened to 20 cycles.
// Notes:   Settings are entered through the keypad menu.
`timescale 1ns/100ps
module dsa_alarm_bench;
  localparam int TICK = 20;
  localparam dsa_pkg::dsa_keys_t K_UP = 4'h8;
  localparam dsa_pkg::dsa_keys_t K_SEL = 4'h2;
  localparam dsa_pkg::dsa_keys_t K_QUIT = 4'h1;
  localparam dsa_pkg::dsa_keys_t K_DOWN = 4'h4;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  logic signed [15:0] disp_value = 16'h0000;
  logic               disp_strobe = 1'b0;
  dsa_pkg::dsa_keys_t keys;
  logic [1:0]         sw;
  logic [1:0]         shown;
  logic               show_id;
  dsa_pkg::dsa_state_t state;
  logic [3:0]         param;
  logic [15:0]        edit;
  logic [1:0]         digit;
  int                 errors = 0;
  int                 compares = 0;
  int                 cycles = 0;
  int                 i;
  always #5 clock = ~clock;
  dsa_alarm #(.TICK_CYCLES(TICK)) dut (.CLOCK(clock), .RST_N(rst_n), .DISP_VALUE(disp_value),
    .DISP_STROBE(disp_strobe), .KEYS(keys), .SWITCH_CLOSED(sw), .ALARM_SHOWN(shown), .SHOW_ALARM_ID(show_id),
    .MENU_STATE(state), .MENU_PARAM(param), .EDIT_VALUE(edit), .EDIT_DIGIT(digit));
  dsa_keypad kp (.clock(clock), .keys(keys));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic strobe(input logic [15:0] v);
    @(posedge clock) disp_value <= v;
    disp_strobe <= 1'b1;
    @(posedge clock) disp_strobe <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Walks the program menu, stores a value, then reopens it to read it back
  task automatic set_par(input int par, input logic [15:0] val, input logic [15:0] exp);
    int d;
    kp.press(K_QUIT);
    repeat (par) kp.press(K_UP);
    kp.press(K_SEL);
    if (state === dsa_pkg::DSA_ST_OPTION) begin
      if (edit[0] !== val[0]) kp.press(K_UP);
    end else begin
      for (d = 3; d >= 0; d--) begin
        repeat (4'(val[4*d+:4] - edit[4*d+:4])) kp.press(K_UP);
        kp.press(K_SEL);
      end
    end
    kp.press(K_QUIT);
    kp.press(K_SEL);
    chk((state === dsa_pkg::DSA_ST_OPTION) ? {15'h0, edit[0]} : edit, exp);
    kp.press(K_QUIT);
    kp.press(K_QUIT);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_DISPLAY));
  endtask
  task automatic t_enable;
    chk({14'h0, sw}, 16'h0003);
    set_par(1, 16'h0064, 16'h0064);
    strobe(16'h0064);
    chk({14'h0, shown}, 16'h0000);
    set_par(0, 16'h0001, 16'h0001);
    strobe(16'h0064);
    chk({14'h0, shown}, 16'h0001);
    chk({14'h0, sw}, 16'h0002);
    $display("enable test done");
  endtask
  task automatic t_band;
    logic id0;
    set_par(4, 16'h000A, 16'h000A);
    strobe(16'h005A);
    chk({14'h0, shown}, 16'h0001);
    strobe(16'h0059);
    chk({14'h0, sw, shown}, 16'h000C);
    strobe(16'h0064);
    id0 = show_id;
    for (i = 0; i < TICK + 3 && show_id === id0; i++) begin
      @(posedge clock);
      #1;
    end
    #1;
    chk({15'h0, show_id}, {15'h0, ~id0});
    strobe(16'h0000);
    $display("deadband test done");
  endtask
  task automatic t_low2;
    set_par(8, 16'hFFF6, 16'hFFF6);
    set_par(9, 16'h0000, 16'h0000);
    set_par(10, 16'h0001, 16'h0001);
    set_par(7, 16'h0001, 16'h0001);
    strobe(16'hFFF6);
    chk({14'h0, sw, shown}, 16'h000E);
    strobe(16'h0000);
    chk({14'h0, sw, shown}, 16'h0004);
    set_par(7, 16'h0000, 16'h0000);
    $display("low alarm test done");
  endtask
  task automatic t_wait;
    set_par(5, 16'hFFFF, 16'h0E10);
    set_par(5, 16'h0003, 16'h0003);
    strobe(16'h0064);
    repeat (2 * TICK - 8) @(posedge clock);
    #1;
    chk({14'h0, shown}, 16'h0000);
    for (i = 0; i < TICK + 12 && shown[0] !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    #1;
    chk({14'h0, shown}, 16'h0001);
    strobe(16'h0000);
    set_par(5, 16'h0000, 16'h0000);
    $display("delay test done");
  endtask
  task automatic t_mute;
    set_par(6, 16'h0002, 16'h0002);
    strobe(16'h0064);
    chk({14'h0, sw}, 16'h0000);
    kp.press(K_SEL);
    chk({14'h0, sw, shown}, 16'h0005);
    for (i = 0; i < 2 * TICK + 5 && sw[0] !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    #1;
    chk({14'h0, sw}, 16'h0000);
    strobe(16'h0000);
    $display("mute test done");
  endtask
  task automatic t_short;
    set_par(14, 16'h0001, 16'h0001);
    kp.chord(K_UP, 4'hA);
    chk({12'h0, param}, 16'(dsa_pkg::PAR_LEVEL1));
    kp.press(K_UP);
    chk({12'h0, param}, 16'(dsa_pkg::PAR_LEVEL2));
    repeat (8 * TICK) @(posedge clock);
    #1;
    chk(16'(state), 16'(dsa_pkg::DSA_ST_SHORT));
    for (i = 0; i < 3 * TICK && state !== dsa_pkg::DSA_ST_DISPLAY; i++) begin
      @(posedge clock);
      #1;
    end
    #1;
    chk(16'(state), 16'(dsa_pkg::DSA_ST_DISPLAY));
    set_par(15, 16'h0001, 16'h0001);
    kp.chord(K_UP, 4'hA);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_CODE));
    kp.press(K_QUIT);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_DISPLAY));
    // Right code, then edit the first level from the shortcut prompt
    kp.chord(K_UP, 4'hA);
    repeat (3) kp.press(K_SEL);
    chk({14'h0, digit}, 16'h0000);
    kp.press(K_UP);
    kp.press(K_QUIT);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_SHORT));
    chk({12'h0, param}, 16'(dsa_pkg::PAR_LEVEL1));
    kp.press(K_SEL);
    chk({14'h0, digit}, 16'(dsa_pkg::DIGIT_TOP));
    kp.press(K_DOWN);
    chk(edit, 16'hF064);
    kp.press(K_QUIT);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_SHORT));
    kp.press(K_QUIT);
    chk(16'(state), 16'(dsa_pkg::DSA_ST_DISPLAY));
    strobe(16'hF064);
    chk({14'h0, shown}, 16'h0001);
    strobe(16'h8000);
    chk({14'h0, shown}, 16'h0000);
    $display("shortcut test done");
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    t_enable();
    t_band();
    t_low2();
    t_wait();
    t_mute();
    t_short();
    finish_test();
  end
endmodule
